// ==== common/fifo_irq_pkg.sv ====
package fifo_irq_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int          NUM_FIFOS       = 32;
  localparam int          COUNT_W         = 22;
  localparam int          LIMIT_W         = 5;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          VIEW_IDX_W      = 5;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_VIEW_BASE   = 12'h198;
  localparam logic [11:0] OFF_VIEW_LAST   = 12'h214;
  localparam logic [11:0] OFF_FLAGS       = 12'h218;
  localparam logic [11:0] OFF_ENABLES     = 12'h21c;
  localparam logic [11:0] OFF_SUM_STATUS  = 12'h220;
  localparam logic [11:0] OFF_SUM_MASK    = 12'h224;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          BIT_NEARLY      = 8;
  localparam int          BIT_DRAINED     = 7;
  localparam int          BIT_SUMMARY     = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_FLAGS       = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLES     = 32'h0000_0000;
  localparam logic [31:0] RST_VIEW_BITS   = 32'hffff_ffff;
  localparam logic        RST_SUMMARY     = 1'b0;
  localparam logic        RST_SUM_MASK    = 1'b0;

  // ---------------------------------------------------------------
  // Almost-empty limit coding
  // ---------------------------------------------------------------
  localparam logic [4:0]  LIMIT_CAP_CODE  = 5'h15;
  localparam logic [21:0] LIMIT_CAP_VALUE = 22'h1f_ffff;

endpackage

// ==== hw/fifo_level_watch.sv ====
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Level watch for one output FIFO
// -----------------------------------------------------------------
// The limit code selects a threshold of two to the power of the code;
// the top codes saturate at the largest threshold.
module fifo_level_watch
  import fifo_irq_pkg::*;
#(
  parameter int CountWidth = COUNT_W
) (
  input  wire logic [CountWidth-1:0] fillCount,
  input  wire logic [LIMIT_W-1:0]    limitCode,
  output      logic                  nearlyDrained,
  output      logic                  drained
);

  logic [CountWidth-1:0] threshold;

  always_comb begin
    if (limitCode >= LIMIT_CAP_CODE) begin
      threshold = CountWidth'(LIMIT_CAP_VALUE);
    end else begin
      threshold = CountWidth'(1) << limitCode;
    end
    nearlyDrained = (fillCount < threshold);
    drained       = (fillCount == '0);
  end

endmodule

// ==== hw/fifo_interrupt_aggregator.sv ====
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// Operation
// - Thirty-two read-only pending flags, bit n-1 for FIFO n, zero after reset.
// - A FIFO's flag sets when its fill drops below its limit.
// - A FIFO's flag sets when the FIFO is empty.
// - A flag sets only while its allow bit is one.
// - Any set flag sets the summary FIFO interrupt bit.
// - The interrupt line rises only while the master enable is set.
// - Flags clear only through a read of the FIFO's own status register.
// - Thirty-two read/write allow bits, bit n-1 for FIFO n, zero after reset.
// - Flags decode at 0x218, allow bits at 0x21c, one word each.
// - Bit 8 of each FIFO status register shows nearly drained, reset one.
module fifo_interrupt_aggregator
  import fifo_irq_pkg::*;
#(
  parameter int CountWidth = COUNT_W
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ADDR_W-1:0]               paddr,
  input  wire logic [DATA_W-1:0]               pwdata,
  input  wire logic [3:0]                      pstrb,
  output      logic [DATA_W-1:0]               prdata,
  output      logic                            pready,
  output      logic                            pslverr,
  input  wire logic [NUM_FIFOS*CountWidth-1:0] fifoFillCount,
  input  wire logic [NUM_FIFOS*LIMIT_W-1:0]    fifoLimitCode,
  output      logic [NUM_FIFOS-1:0]            fifoPendingFlag,
  output      logic [NUM_FIFOS-1:0]            fifoPendingAllow,
  output      logic                            fifoSummary,
  output      logic                            pciIrq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_FIFOS-1:0] flags;
    logic [NUM_FIFOS-1:0] allow;
    logic [NUM_FIFOS-1:0] nearlyView;
    logic [NUM_FIFOS-1:0] drainedView;
    logic                 summary;
    logic                 sumMask;
    logic                 sumSnap;
    logic                 irq;
    logic [DATA_W-1:0]    rdata;
    logic                 ready;
    logic                 err;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NUM_FIFOS-1:0]  nearlyVec;
  logic [NUM_FIFOS-1:0]  drainedVec;
  logic [NUM_FIFOS-1:0]  setVec;
  logic [NUM_FIFOS-1:0]  clrVec;
  logic                  latchCycle;
  logic                  doneCycle;
  logic                  selView;
  logic                  selFlags;
  logic                  selEnables;
  logic                  selSumStatus;
  logic                  selSumMask;
  logic                  addrHit;
  logic [ADDR_W-1:0]     viewOffset;
  logic [VIEW_IDX_W-1:0] viewIdx;
  logic [DATA_W-1:0]     readValue;

  // ---------------------------------------------------------------
  // Per-FIFO level watch
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_FIFOS; g++) begin : gWatch
    fifo_level_watch #(
      .CountWidth (CountWidth)
    ) uWatch (
      .fillCount     (fifoFillCount[g*CountWidth +: CountWidth]),
      .limitCode     (fifoLimitCode[g*LIMIT_W +: LIMIT_W]),
      .nearlyDrained (nearlyVec[g]),
      .drained       (drainedVec[g])
    );
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // The first access cycle latches read data and raises pready, so the
  // register effects happen at the second access edge.
  assign latchCycle = psel & penable & ~state_reg.ready;
  assign doneCycle  = psel & penable & state_reg.ready;
  assign viewOffset = paddr - OFF_VIEW_BASE;
  assign viewIdx    = viewOffset[VIEW_IDX_W+1:2];

  always_comb begin
    selView      = 1'b0;
    selFlags     = 1'b0;
    selEnables   = 1'b0;
    selSumStatus = 1'b0;
    selSumMask   = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      selView = 1'b0;
    end else if (paddr >= OFF_VIEW_BASE && paddr <= OFF_VIEW_LAST) begin
      selView = 1'b1;
    end else if (paddr == OFF_FLAGS) begin
      selFlags = 1'b1;
    end else if (paddr == OFF_ENABLES) begin
      selEnables = 1'b1;
    end else if (paddr == OFF_SUM_STATUS) begin
      selSumStatus = 1'b1;
    end else if (paddr == OFF_SUM_MASK) begin
      selSumMask = 1'b1;
    end
    addrHit = selView | selFlags | selEnables | selSumStatus | selSumMask;
  end

  always_comb begin
    readValue = '0;
    if (selView) begin
      readValue[BIT_NEARLY]  = state_reg.nearlyView[viewIdx];
      readValue[BIT_DRAINED] = state_reg.drainedView[viewIdx];
    end else if (selFlags) begin
      readValue = state_reg.flags;
    end else if (selEnables) begin
      readValue = state_reg.allow;
    end else if (selSumStatus) begin
      readValue[BIT_SUMMARY] = state_reg.summary;
    end else if (selSumMask) begin
      readValue[BIT_SUMMARY] = state_reg.sumMask;
    end
  end

  // ---------------------------------------------------------------
  // Flag set and clear terms
  // ---------------------------------------------------------------
  assign setVec = state_reg.allow & (nearlyVec | drainedVec);

  always_comb begin
    clrVec = '0;
    if (doneCycle && !pwrite && selView) begin
      clrVec[viewIdx] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // A live condition wins over a clear in the same cycle.
    state_next.flags       = setVec | (state_reg.flags & ~clrVec);
    state_next.nearlyView  = nearlyVec;
    state_next.drainedView = drainedVec;
    if (doneCycle && !pwrite && selSumStatus) begin
      state_next.summary = (|state_reg.flags) | (state_reg.summary & ~state_reg.sumSnap);
    end else begin
      state_next.summary = (|state_reg.flags) | state_reg.summary;
    end
    if (doneCycle && pwrite && selEnables) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          state_next.allow[8*b +: 8] = pwdata[8*b +: 8];
        end
      end
    end
    if (doneCycle && pwrite && selSumMask && pstrb[0]) begin
      state_next.sumMask = pwdata[BIT_SUMMARY];
    end
    if (latchCycle) begin
      state_next.rdata   = pwrite ? '0 : readValue;
      state_next.ready   = 1'b1;
      state_next.err     = ~addrHit;
      state_next.sumSnap = state_reg.summary;
    end else begin
      state_next.rdata   = '0;
      state_next.ready   = 1'b0;
      state_next.err     = 1'b0;
    end
    state_next.irq = state_next.summary & state_next.sumMask;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.flags       <= RST_FLAGS;
      state_reg.allow       <= RST_ENABLES;
      state_reg.nearlyView  <= RST_VIEW_BITS;
      state_reg.drainedView <= RST_VIEW_BITS;
      state_reg.summary     <= RST_SUMMARY;
      state_reg.sumMask     <= RST_SUM_MASK;
      state_reg.sumSnap     <= 1'b0;
      state_reg.irq         <= 1'b0;
      state_reg.rdata       <= '0;
      state_reg.ready       <= 1'b0;
      state_reg.err         <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata           = state_reg.rdata;
  assign pready           = state_reg.ready;
  assign pslverr          = state_reg.err;
  assign fifoPendingFlag  = state_reg.flags;
  assign fifoPendingAllow = state_reg.allow;
  assign fifoSummary      = state_reg.summary;
  assign pciIrq           = state_reg.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic viewReadDone;

  assign viewReadDone = doneCycle & ~pwrite & selView;

  sequence s_latch_flags;
    latchCycle && !pwrite && paddr == OFF_FLAGS;
  endsequence

  sequence s_answer_flags;
    pready && !pslverr && prdata == $past(state_reg.flags);
  endsequence

  property p_reset_clear;
    @(posedge clk) rst |=> (fifoPendingFlag == '0 && fifoPendingAllow == '0
                            && state_reg.nearlyView == RST_VIEW_BITS);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags, allow bits or view bits wrong after reset");

  property p_cond_sets;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((fifoPendingFlag & $past(setVec)) == $past(setVec));
  endproperty
  a_cond_sets: assert property (p_cond_sets)
    else $error("enabled drain condition did not set its flag");

  property p_disabled_quiet;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((fifoPendingFlag & ~$past(fifoPendingFlag) & ~$past(fifoPendingAllow)) == '0);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("a disabled FIFO raised its flag");

  property p_summary;
    @(posedge clk) disable iff (rst) (|fifoPendingFlag) |=> fifoSummary;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bit not set while a flag is pending");

  property p_master_gate;
    @(posedge clk) disable iff (rst)
      !state_reg.sumMask |-> !pciIrq;
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("interrupt raised without master enable");

  property p_clear_source;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (($past(fifoPendingFlag) & ~fifoPendingFlag & ~$past(clrVec)) == '0);
  endproperty
  a_clear_source: assert property (p_clear_source)
    else $error("flag cleared without a status register read");

  property p_allow_write;
    @(posedge clk) disable iff (rst)
      (doneCycle && pwrite && selEnables && pstrb == 4'hf)
        |=> fifoPendingAllow == $past(pwdata);
  endproperty
  a_allow_write: assert property (p_allow_write)
    else $error("allow register write not taken");

  property p_flags_read;
    @(posedge clk) disable iff (rst) s_latch_flags |=> s_answer_flags;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flag register read returned wrong data");

  property p_view_bit;
    @(posedge clk) disable iff (rst)
      (latchCycle && !pwrite && selView)
        |=> prdata[BIT_NEARLY] == $past(state_reg.nearlyView[viewIdx]);
  endproperty
  a_view_bit: assert property (p_view_bit)
    else $error("status view read shows wrong nearly drained bit");

  property p_read_clears;
    @(posedge clk) disable iff (rst)
      (viewReadDone && !setVec[viewIdx]) |=> !fifoPendingFlag[$past(viewIdx)];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status register read did not clear its flag");

  property p_ready_pulse;
    @(posedge clk) disable iff (rst) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stood longer than one cycle");

  sequence s_latch_unmapped;
    latchCycle && !addrHit;
  endsequence

  sequence s_answer_error;
    pready && pslverr && prdata == '0;
  endsequence

  property p_bad_addr;
    @(posedge clk) disable iff (rst) s_latch_unmapped |=> s_answer_error;
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("unmapped access not answered with an error");

  property p_irq_raise;
    @(posedge clk) disable iff (rst) (fifoSummary && state_reg.sumMask) |-> pciIrq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("pending summary with master enable did not raise the interrupt");

  property p_allow_hold;
    @(posedge clk) disable iff (rst)
      !(doneCycle && pwrite && selEnables) |=> $stable(fifoPendingAllow);
  endproperty
  a_allow_hold: assert property (p_allow_hold)
    else $error("allow bits changed without a write");

  property p_summary_sticky;
    @(posedge clk) disable iff (rst)
      (fifoSummary && !(doneCycle && !pwrite && selSumStatus)) |=> fifoSummary;
  endproperty
  a_summary_sticky: assert property (p_summary_sticky)
    else $error("summary bit dropped without a status read");

  property p_view_drained;
    @(posedge clk) disable iff (rst)
      (latchCycle && !pwrite && selView)
        |=> prdata[BIT_DRAINED] == $past(state_reg.drainedView[viewIdx]);
  endproperty
  a_view_drained: assert property (p_view_drained)
    else $error("status view read shows wrong empty bit");

endmodule

// ==== tb/fifo_source_model.sv ====
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Output FIFO level source
// ---------------------------------------------------------------
// Holds the unconverted count and the limit code of every FIFO.
// One FIFO is reloaded per strobe.
module fifo_source_model
  import fifo_irq_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         loadEn,
  input  wire logic [4:0]                   loadIdx,
  input  wire logic [COUNT_W-1:0]           loadCount,
  input  wire logic [LIMIT_W-1:0]           loadCode,
  output      logic [NUM_FIFOS*COUNT_W-1:0] fillCount,
  output      logic [NUM_FIFOS*LIMIT_W-1:0] limitCode
);
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_FIFOS; i++) begin
        fillCount[i*COUNT_W +: COUNT_W] <= 22'h00_0064;
        limitCode[i*LIMIT_W +: LIMIT_W] <= 5'h03;
      end
    end else if (loadEn) begin
      fillCount[loadIdx*COUNT_W +: COUNT_W] <= loadCount;
      limitCode[loadIdx*LIMIT_W +: LIMIT_W] <= loadCode;
    end
  end
endmodule

// ==== tb/fifo_interrupt_aggregator_tb.sv ====
`timescale 1ns/1ps

module fifo_interrupt_aggregator_tb
  import fifo_irq_pkg::*;
;
  logic                         clk;
  logic                         rst;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [ADDR_W-1:0]            paddr;
  logic [DATA_W-1:0]            pwdata;
  logic [3:0]                   pstrb;
  logic [DATA_W-1:0]            prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         loadEn;
  logic [4:0]                   loadIdx;
  logic [COUNT_W-1:0]           loadCount;
  logic [LIMIT_W-1:0]           loadCode;
  logic [NUM_FIFOS*COUNT_W-1:0] fillCount;
  logic [NUM_FIFOS*LIMIT_W-1:0] limitCode;
  logic [NUM_FIFOS-1:0]         pendFlag;
  logic [NUM_FIFOS-1:0]         pendAllow;
  logic                         summary;
  logic                         pciIrq;
  logic [DATA_W-1:0]            rdData;
  logic                         rdErr;
  int                           failCount;
  int                           totalChecks;

  fifo_interrupt_aggregator #(.CountWidth(COUNT_W)) u_fifo_interrupt_aggregator (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifoFillCount(fillCount),
    .fifoLimitCode(limitCode), .fifoPendingFlag(pendFlag),
    .fifoPendingAllow(pendAllow), .fifoSummary(summary), .pciIrq(pciIrq)
  );

  fifo_source_model u_fifo_source_model (
    .clk(clk), .rst(rst), .loadEn(loadEn), .loadIdx(loadIdx),
    .loadCount(loadCount), .loadCode(loadCode), .fillCount(fillCount),
    .limitCode(limitCode)
  );

  always #2 clk = ~clk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic isWrite, input logic [11:0] addr, input logic [31:0] data,
                     input logic [3:0] strb);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= isWrite;
    paddr   <= addr;
    pwdata  <= data;
    pstrb   <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] addr);
    apb(1'b0, addr, 32'h0000_0000, 4'h0);
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
    apb(1'b1, addr, data, strb);
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Reloads one FIFO, then lets the flag and summary stages settle.
  task automatic setFifo(input logic [4:0] idx, input logic [COUNT_W-1:0] cnt,
                         input logic [LIMIT_W-1:0] code);
    @(posedge clk);
    loadEn    <= 1'b1;
    loadIdx   <= idx;
    loadCount <= cnt;
    loadCode  <= code;
    @(posedge clk);
    loadEn <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    pstrb       = 4'h0;
    loadEn      = 1'b0;
    loadIdx     = 5'h00;
    loadCount   = 22'h00_0000;
    loadCode    = 5'h03;
    failCount   = 0;
    totalChecks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("flagPort", 32'h0000_0000, pendFlag);
    rd(OFF_FLAGS);
    chk("flags", 32'h0000_0000, rdData);
    chk("flagsErr", 32'h0000_0000, 32'(rdErr));
    rd(OFF_ENABLES);
    chk("enables", 32'h0000_0000, rdData);
    rd(12'h300);
    chk("unmappedErr", 32'h0000_0001, 32'(rdErr));
    chk("unmappedData", 32'h0000_0000, rdData);
    rd(12'h219);
    chk("misalignedErr", 32'h0000_0001, 32'(rdErr));
    setFifo(5'h04, 22'h00_0000, 5'h03);
    chk("flagDisabled", 32'h0000_0000, pendFlag);
    chk("summaryIdle", 32'h0000_0000, 32'(summary));
    // FIFOs 1 to 4 stand for converters outside FIFO mode and stay disabled.
    wr(OFF_ENABLES, 32'h0000_0030, 4'hf);
    wr(OFF_ENABLES, 32'hffff_ffff, 4'h2);
    rd(OFF_ENABLES);
    chk("enablesLane", 32'h0000_ff30, rdData);
    chk("allowPort", 32'h0000_ff30, pendAllow);
    repeat (3) @(posedge clk);
    chk("flagEmpty", 32'h0000_0010, pendFlag);
    chk("summarySet", 32'h0000_0001, 32'(summary));
    chk("irqMasked", 32'h0000_0000, 32'(pciIrq));
    setFifo(5'h05, 22'h00_0008, 5'h03);
    chk("flagAtLimit", 32'h0000_0010, pendFlag);
    setFifo(5'h05, 22'h00_0007, 5'h03);
    chk("flagBelow", 32'h0000_0030, pendFlag);
    wr(OFF_FLAGS, 32'h0000_0000, 4'hf);
    chk("roWriteErr", 32'h0000_0000, 32'(rdErr));
    rd(OFF_FLAGS);
    chk("flagsRo", 32'h0000_0030, rdData);
    wr(OFF_SUM_MASK, 32'h0000_0001, 4'h1);
    repeat (2) @(posedge clk);
    chk("irqOn", 32'h0000_0001, 32'(pciIrq));
    rd(OFF_SUM_MASK);
    chk("maskRead", 32'h0000_0001, rdData);
    rd(12'h1a8);
    chk("viewEmpty", 32'h0000_0180, rdData);
    repeat (2) @(posedge clk);
    chk("flagLive", 32'h0000_0030, pendFlag);
    setFifo(5'h05, 22'h00_0064, 5'h03);
    rd(12'h1ac);
    chk("viewFull", 32'h0000_0000, rdData);
    repeat (2) @(posedge clk);
    chk("flagCleared", 32'h0000_0010, pendFlag);
    setFifo(5'h04, 22'h00_0064, 5'h03);
    rd(12'h1a8);
    rd(OFF_SUM_STATUS);
    chk("summaryRead", 32'h0000_0001, rdData);
    repeat (2) @(posedge clk);
    chk("flagsNone", 32'h0000_0000, pendFlag);
    chk("summaryClr", 32'h0000_0000, 32'(summary));
    chk("irqOff", 32'h0000_0000, 32'(pciIrq));
    // Limit codes above the cap use the largest threshold; code zero means one value.
    setFifo(5'h08, LIMIT_CAP_VALUE - 22'h00_0001, 5'h1f);
    chk("flagCapBelow", 32'h0000_0100, pendFlag);
    chk("irqAgain", 32'h0000_0001, 32'(pciIrq));
    setFifo(5'h08, LIMIT_CAP_VALUE, 5'h1f);
    rd(12'h1b8);
    chk("viewCap", 32'h0000_0000, rdData);
    repeat (2) @(posedge clk);
    chk("flagCapAt", 32'h0000_0000, pendFlag);
    setFifo(5'h09, 22'h00_0001, 5'h00);
    chk("flagCodeZero", 32'h0000_0000, pendFlag);
    // Periodic waveform output runs with every FIFO interrupt disabled.
    wr(OFF_ENABLES, 32'h0000_0000, 4'hf);
    setFifo(5'h05, 22'h00_0000, 5'h03);
    chk("flagPeriodic", 32'h0000_0000, pendFlag);
    results;
  end

  initial begin
    #80000;
    failCount++;
    $display("mismatch watchdog expected done seen hang");
    results;
  end
endmodule
